/* File: logic/sfl_pkg.sv */
// constants for the sample fifo, limit check and readout block
package sfl_pkg;
    localparam int          SFL_ADDR_W        = 8;
    localparam int          SFL_DATA_W        = 16;
    localparam int          SFL_LIMIT_W       = 12;
    localparam int          SFL_LREG_W        = 24;
    localparam int          SFL_FIFO_DEPTH    = 32;
    localparam int          SFL_CHAN_N        = 16;
    localparam int          SFL_CHAN_W        = 4;
    localparam logic [7:0]  SFL_LIMIT_ADDR    = 8'h3c;
    localparam logic [7:0]  SFL_READ_ADDR     = 8'h3d;
    localparam logic [7:0]  SFL_STATUS_ADDR   = 8'h3b;
    localparam int          SFL_UPPER_MSB     = 23;
    localparam int          SFL_UPPER_LSB     = 12;
    localparam int          SFL_LOWER_MSB     = 11;
    localparam int          SFL_LOWER_LSB     = 0;
    localparam logic [23:0] SFL_LIMIT_RESET   = 24'hfff000;
    localparam logic [15:0] SFL_READ_RESET    = 16'h0000;
    localparam int          SFL_ST_EMPTY_BIT  = 0;
    localparam int          SFL_ST_UPPER_BIT  = 1;
    localparam int          SFL_ST_LOWER_BIT  = 2;
    localparam int          SFL_SAMPLE_MSB    = 15;
    localparam int          SFL_SAMPLE_LSB    = 4;
endpackage : sfl_pkg

/* File: logic/sfl_fifo.sv */
// parameterised synchronous fifo with valid/ready on both sides and flush
`timescale 1ns/1ps
module sfl_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input  wire logic                      ref_clk,
    input  wire logic                      reset,
    input  wire logic                      flush,
    input  wire logic                      in_valid,
    output logic                           in_ready,
    input  wire logic [WIDTH-1:0]          in_data,
    output logic                           out_valid,
    input  wire logic                      out_ready,
    output logic [WIDTH-1:0]               out_data,
    output logic [$clog2(DEPTH):0]         level
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } sfl_fifo_state_type;

    sfl_fifo_state_type s_q, s_d;
    logic [WIDTH-1:0]   mem [DEPTH];
    logic               push;
    logic               pop;

    assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
    assign out_valid = (s_q.cnt != '0);
    assign out_data  = mem[s_q.rd];
    assign level     = s_q.cnt;
    assign push      = in_valid & in_ready & ~flush;
    assign pop       = out_valid & out_ready & ~flush;

    always_comb begin
        s_d = s_q;
        if (flush) begin
            s_d = '0;
        end else begin
            if (push) begin
                s_d.wr = s_q.wr + 1'b1;
            end
            if (pop) begin
                s_d.rd = s_q.rd + 1'b1;
            end
            case ({push, pop})
                2'b10:   s_d.cnt = s_q.cnt + 1'b1;
                2'b01:   s_d.cnt = s_q.cnt - 1'b1;
                default: s_d.cnt = s_q.cnt;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[s_q.wr] <= in_data;
        end
    end

    property p_fifo_no_overfill;
        @(posedge ref_clk) disable iff (reset) s_q.cnt <= (AW+1)'(DEPTH);
    endproperty
    a_fifo_no_overfill: assert property (p_fifo_no_overfill)
        else $error("fifo count above depth");
endmodule : sfl_fifo

/* File: logic/sfl_top.sv */
// sample fifo tail: empty flag, limit comparison and data read port
`timescale 1ns/1ps
// Summary of operation
// - empty flag is high with no entries and resets to one
// - empty after enable without data, after last read, after clear command
// - empty flag held at one while the fifo is disabled
// - empty flag drops to zero once any entry is stored
// - empty interrupt follows the empty flag in the same cycles
// - enabled channel sample at or above upper limit sets upper hit
// - enabled channel sample at or below lower limit sets lower hit
// - read of data port returns a 16-bit stored sample; port read-only
// - limit register at 0x3c resets to upper full scale, lower zero
// - lower hit and its interrupt clear when the fifo is emptied
module sfl_top
    import sfl_pkg::*;
#(
    parameter int DEPTH  = SFL_FIFO_DEPTH,
    parameter int CHAN_N = SFL_CHAN_N
) (
    input  wire logic                    ref_clk,
    input  wire logic                    reset,
    input  wire logic                    fifo_enable,
    input  wire logic                    fifo_clear,
    input  wire logic [CHAN_N-1:0]       channel_limit_check_on,
    input  wire logic                    sample_valid,
    output logic                         sample_ready,
    input  wire logic [SFL_DATA_W-1:0]   sample_data,
    input  wire logic [SFL_CHAN_W-1:0]   sample_chan,
    input  wire logic [SFL_ADDR_W-1:0]   reg_addr,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    input  wire logic [SFL_LREG_W-1:0]   reg_wdata,
    output logic [SFL_LREG_W-1:0]        reg_rdata,
    output logic                         reg_rvalid,
    output logic                         empty_flag,
    output logic                         empty_irq,
    output logic                         upper_limit_hit,
    output logic                         lower_limit_hit,
    output logic                         upper_limit_irq,
    output logic                         lower_limit_irq,
    output logic [$clog2(DEPTH):0]       fifo_level
);
    typedef struct packed {
        logic [SFL_LREG_W-1:0] limits;
        logic [SFL_LREG_W-1:0] rdata;
        logic                  rvalid;
        logic                  upper_hit;
        logic                  lower_hit;
        logic                  enable_seen;
    } sfl_state_type;

    sfl_state_type s_q, s_d;

    logic                    fifo_in_valid;
    logic                    fifo_in_ready;
    logic                    fifo_out_valid;
    logic                    fifo_out_ready;
    logic [SFL_DATA_W-1:0]   fifo_out_data;
    logic [$clog2(DEPTH):0]  level;
    logic                    flush;
    logic                    store;
    logic                    chan_check;
    logic                    hits_upper;
    logic                    hits_lower;
    logic                    read_port;
    logic                    emptied;

    function automatic logic addr_is(input logic [SFL_ADDR_W-1:0] a,
                                     input logic [SFL_ADDR_W-1:0] b);
        addr_is = (a == b);
    endfunction : addr_is

    // flush on clear command or while disabled
    assign flush          = fifo_clear | ~fifo_enable;
    assign fifo_in_valid  = sample_valid & fifo_enable;
    assign sample_ready   = fifo_in_ready & fifo_enable;
    assign store          = fifo_in_valid & fifo_in_ready & ~fifo_clear;
    assign read_port      = reg_rd & addr_is(reg_addr, SFL_READ_ADDR);
    assign fifo_out_ready = read_port;
    assign chan_check     = channel_limit_check_on[sample_chan];
    // top 12 bits of the sample are compared against the 12-bit limits
    assign hits_upper     = sample_data[SFL_SAMPLE_MSB:SFL_SAMPLE_LSB]
                            >= s_q.limits[SFL_UPPER_MSB:SFL_UPPER_LSB];
    assign hits_lower     = sample_data[SFL_SAMPLE_MSB:SFL_SAMPLE_LSB]
                            <= s_q.limits[SFL_LOWER_MSB:SFL_LOWER_LSB];
    assign emptied        = (level == '0);

    sfl_fifo #(
        .WIDTH (SFL_DATA_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .flush     (flush),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (sample_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data),
        .level     (level)
    );

    always_comb begin
        s_d        = s_q;
        s_d.rvalid = 1'b0;
        s_d.enable_seen = fifo_enable;
        if (reg_wr && addr_is(reg_addr, SFL_LIMIT_ADDR)) begin
            s_d.limits = reg_wdata;
        end
        if (reg_rd) begin
            s_d.rvalid = 1'b1;
            if (addr_is(reg_addr, SFL_LIMIT_ADDR)) begin
                s_d.rdata = s_q.limits;
            end else if (read_port) begin
                s_d.rdata = fifo_out_valid ? {8'h00, fifo_out_data}
                                           : {8'h00, SFL_READ_RESET};
            end else if (addr_is(reg_addr, SFL_STATUS_ADDR)) begin
                s_d.rdata = '0;
                s_d.rdata[SFL_ST_EMPTY_BIT] = empty_flag;
                s_d.rdata[SFL_ST_UPPER_BIT] = s_q.upper_hit;
                s_d.rdata[SFL_ST_LOWER_BIT] = s_q.lower_hit;
            end else begin
                s_d.rdata = '0;
            end
        end
        // hits clear when the fifo holds nothing; a new hit wins
        if (emptied) begin
            s_d.lower_hit = 1'b0;
            s_d.upper_hit = 1'b0;
        end
        if (store && chan_check && hits_upper) begin
            s_d.upper_hit = 1'b1;
        end
        if (store && chan_check && hits_lower) begin
            s_d.lower_hit = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_q             <= '0;
            s_q.limits      <= SFL_LIMIT_RESET;
            s_q.rdata       <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // empty is held high when disabled and follows the fifo count otherwise
    assign empty_flag      = ~fifo_enable | emptied;
    assign empty_irq       = empty_flag;
    assign upper_limit_hit = s_q.upper_hit;
    assign lower_limit_hit = s_q.lower_hit;
    assign upper_limit_irq = s_q.upper_hit;
    assign lower_limit_irq = s_q.lower_hit;
    assign reg_rdata       = s_q.rdata;
    assign reg_rvalid      = s_q.rvalid;
    assign fifo_level      = level;

    // ------------------------------------------------------------ checks
    property p_empty_reset;
        @(posedge ref_clk) $fell(reset) |-> $past(empty_flag) == 1'b1;
    endproperty
    a_empty_reset: assert property (p_empty_reset)
        else $error("empty flag not one at reset");

    property p_empty_on_zero;
        @(posedge ref_clk) disable iff (reset) (level == '0) |-> empty_flag;
    endproperty
    a_empty_on_zero: assert property (p_empty_on_zero)
        else $error("empty flag low with no entries");

    property p_clear_empties;
        @(posedge ref_clk) disable iff (reset) fifo_clear ##1 !fifo_clear |-> empty_flag;
    endproperty
    a_clear_empties: assert property (p_clear_empties)
        else $error("fifo not empty after clear command");

    property p_last_read;
        @(posedge ref_clk) disable iff (reset)
            (level == 1 && read_port && !store && !flush) |=> empty_flag;
    endproperty
    a_last_read: assert property (p_last_read)
        else $error("fifo not empty after last entry read");

    property p_disabled_empty;
        @(posedge ref_clk) disable iff (reset) !fifo_enable |-> empty_flag;
    endproperty
    a_disabled_empty: assert property (p_disabled_empty)
        else $error("empty flag low while disabled");

    property p_store_clears_empty;
        @(posedge ref_clk) disable iff (reset)
            store && !read_port && fifo_enable ##1 fifo_enable && !fifo_clear |-> !empty_flag;
    endproperty
    a_store_clears_empty: assert property (p_store_clears_empty)
        else $error("empty flag high with an entry stored");

    property p_irq_tracks;
        @(posedge ref_clk) disable iff (reset) empty_irq == empty_flag;
    endproperty
    a_irq_tracks: assert property (p_irq_tracks)
        else $error("empty interrupt differs from empty flag");

    property p_upper_set;
        @(posedge ref_clk) disable iff (reset)
            store && chan_check && hits_upper |=> upper_limit_hit && upper_limit_irq;
    endproperty
    a_upper_set: assert property (p_upper_set)
        else $error("upper hit not set");

    property p_lower_set;
        @(posedge ref_clk) disable iff (reset)
            store && chan_check && hits_lower |=> lower_limit_hit;
    endproperty
    a_lower_set: assert property (p_lower_set)
        else $error("lower hit not set");

    property p_no_hit_unchecked;
        @(posedge ref_clk) disable iff (reset)
            $rose(lower_limit_hit) |-> $past(store && chan_check && hits_lower);
    endproperty
    a_no_hit_unchecked: assert property (p_no_hit_unchecked)
        else $error("lower hit set without cause");

    property p_read_data;
        @(posedge ref_clk) disable iff (reset)
            read_port && fifo_out_valid |=> reg_rvalid && reg_rdata[15:0] == $past(fifo_out_data)
                && reg_rdata[23:16] == 8'h00;
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("data port returned wrong sample");

    property p_limit_write;
        @(posedge ref_clk) disable iff (reset)
            reg_wr && reg_addr == SFL_LIMIT_ADDR ##1 !reg_wr
            ##1 reg_rd && reg_addr == SFL_LIMIT_ADDR |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    a_limit_write: assert property (p_limit_write)
        else $error("limit register readback mismatch");

    property p_lower_clears;
        @(posedge ref_clk) disable iff (reset)
            emptied && !store |=> !lower_limit_hit && !lower_limit_irq;
    endproperty
    a_lower_clears: assert property (p_lower_clears)
        else $error("lower hit not cleared on empty");

    property p_pop_one;
        @(posedge ref_clk) disable iff (reset)
            read_port && fifo_out_valid && !store && !flush |=> level == $past(level) - 1'b1;
    endproperty
    a_pop_one: assert property (p_pop_one)
        else $error("read did not remove one entry");

    property p_fresh_enable;
        @(posedge ref_clk) disable iff (reset) fifo_enable && !s_q.enable_seen |-> empty_flag;
    endproperty
    a_fresh_enable: assert property (p_fresh_enable)
        else $error("fifo not empty when freshly enabled");

    property p_limit_reset;
        @(posedge ref_clk) $fell(reset) |-> s_q.limits == SFL_LIMIT_RESET && !reg_rvalid;
    endproperty
    a_limit_reset: assert property (p_limit_reset)
        else $error("limit register not at reset value");

    property p_upper_no_cause;
        @(posedge ref_clk) disable iff (reset)
            $rose(upper_limit_hit) |-> $past(store && chan_check && hits_upper);
    endproperty
    a_upper_no_cause: assert property (p_upper_no_cause)
        else $error("upper hit set without cause");

    property p_upper_clears;
        @(posedge ref_clk) disable iff (reset)
            emptied && !store |=> !upper_limit_hit && !upper_limit_irq;
    endproperty
    a_upper_clears: assert property (p_upper_clears)
        else $error("upper hit not cleared on empty");

    property p_rvalid_pulse;
        @(posedge ref_clk) disable iff (reset) reg_rd |=> reg_rvalid;
    endproperty
    a_rvalid_pulse: assert property (p_rvalid_pulse)
        else $error("read not answered in the next cycle");

    property p_rvalid_idle;
        @(posedge ref_clk) disable iff (reset) !reg_rd |=> !reg_rvalid;
    endproperty
    a_rvalid_idle: assert property (p_rvalid_idle)
        else $error("read answer without a read");

    property p_empty_read_no_pop;
        @(posedge ref_clk) disable iff (reset)
            read_port && !fifo_out_valid && !store && !flush |=> level == $past(level);
    endproperty
    a_empty_read_no_pop: assert property (p_empty_read_no_pop)
        else $error("read of empty fifo changed the level");

    property p_port_read_only;
        @(posedge ref_clk) disable iff (reset)
            reg_wr && !reg_rd && addr_is(reg_addr, SFL_READ_ADDR) && !store && !flush
            |=> level == $past(level);
    endproperty
    a_port_read_only: assert property (p_port_read_only)
        else $error("write to data port changed the fifo");

    c_fill:      cover property (@(posedge ref_clk) disable iff (reset) !sample_ready && fifo_enable);
    c_drain:     cover property (@(posedge ref_clk) disable iff (reset) $rose(empty_flag) && fifo_enable);
    c_upper:     cover property (@(posedge ref_clk) disable iff (reset) $rose(upper_limit_hit));
    c_lower_clr: cover property (@(posedge ref_clk) disable iff (reset) $fell(lower_limit_hit));
endmodule : sfl_top

/* File: bench/sfl_host.sv */
// host model: register master for the limit and read port registers
`timescale 1ns/1ps
module sfl_host
    import sfl_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic [SFL_LREG_W-1:0] reg_rdata,
    input  wire logic                  reg_rvalid,
    output logic [SFL_ADDR_W-1:0]      reg_addr,
    output logic                       reg_wr,
    output logic                       reg_rd,
    output logic [SFL_LREG_W-1:0]      reg_wdata
);
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 24'h000000;
    end
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr
    // read strobe, then wait a bounded time for the answer
    task automatic rd(input logic [7:0] a, output logic [23:0] d);
        int n;
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        n = 0;
        while (reg_rvalid !== 1'b1 && n < 4) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        d = (reg_rvalid === 1'b1) ? reg_rdata : 24'hxxxxxx;
    endtask : rd
endmodule : sfl_host

/* File: bench/tb_top.sv */
// self-checking bench for the sample fifo tail block
`timescale 1ns/1ps
module tb_top
    import sfl_pkg::*;
;
    logic        ref_clk, reset, fifo_enable, fifo_clear, sample_valid, sample_ready;
    logic [15:0] channel_limit_check_on, sample_data;
    logic [3:0]  sample_chan;
    logic [7:0]  reg_addr;
    logic        reg_wr, reg_rd, reg_rvalid, empty_flag, empty_irq;
    logic [23:0] reg_wdata, reg_rdata, d;
    logic        upper_limit_hit, lower_limit_hit, upper_limit_irq, lower_limit_irq;
    logic [5:0]  fifo_level;
    int          mismatches, samples_checked, cyc;

    sfl_top dut (.ref_clk(ref_clk), .reset(reset), .fifo_enable(fifo_enable),
        .fifo_clear(fifo_clear), .channel_limit_check_on(channel_limit_check_on),
        .sample_valid(sample_valid), .sample_ready(sample_ready),
        .sample_data(sample_data), .sample_chan(sample_chan), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .empty_flag(empty_flag), .empty_irq(empty_irq),
        .upper_limit_hit(upper_limit_hit), .lower_limit_hit(lower_limit_hit),
        .upper_limit_irq(upper_limit_irq), .lower_limit_irq(lower_limit_irq),
        .fifo_level(fifo_level));
    sfl_host host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            results();
        end
    end

    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic push(input logic [15:0] v, input logic [3:0] c);
        int n;
        @(posedge ref_clk);
        sample_valid <= 1'b1;
        sample_data  <= v;
        sample_chan  <= c;
        #1;
        n = 0;
        while (sample_ready !== 1'b1 && n < 8) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        @(posedge ref_clk);
        sample_valid <= 1'b0;
        sample_data  <= ~v;
        #1;
    endtask : push
    task automatic pulse_clear();
        @(posedge ref_clk);
        fifo_clear <= 1'b1;
        @(posedge ref_clk);
        fifo_clear <= 1'b0;
        #1;
    endtask : pulse_clear
    task automatic t_reset();
        chk("empty_flag", 1, empty_flag);
        chk("empty_irq", 1, empty_irq);
        host.rd(SFL_LIMIT_ADDR, d);
        chk("limit reset", SFL_LIMIT_RESET, d);
        host.rd(SFL_READ_ADDR, d);
        chk("empty read", 0, d);
        host.rd(8'h10, d);
        chk("unmapped read", 0, d);
        host.rd(SFL_STATUS_ADDR, d);
        chk("status reset", 24'h000001, d);
    endtask : t_reset
    task automatic t_limits();
        host.wr(SFL_LIMIT_ADDR, 24'h800100);
        host.rd(SFL_LIMIT_ADDR, d);
        chk("limit rw", 24'h800100, d);
        pulse_clear();
        @(posedge ref_clk);
        channel_limit_check_on <= 16'h0004;
        push(16'h1000, 4'h2);
        chk("lower hit", 1, lower_limit_hit);
        chk("lower irq", 1, lower_limit_irq);
        chk("upper early", 0, upper_limit_hit);
        chk("empty stored", 0, empty_flag);
        chk("empty_irq low", 0, empty_irq);
        push(16'h8000, 4'h2);
        chk("upper hit", 1, upper_limit_hit);
        chk("upper irq", 1, upper_limit_irq);
        host.rd(SFL_STATUS_ADDR, d);
        chk("status hits", 24'h000006, d);
        push(16'h1234, 4'h2);
        chk("level", 3, fifo_level);
        host.rd(SFL_READ_ADDR, d);
        chk("read 1", 24'h001000, d);
        host.rd(SFL_READ_ADDR, d);
        chk("read 2", 24'h008000, d);
        host.rd(SFL_READ_ADDR, d);
        chk("read 3", 24'h001234, d);
        chk("empty last read", 1, empty_flag);
        @(posedge ref_clk);
        #1;
        chk("lower cleared", 0, lower_limit_hit);
        chk("lower irq cleared", 0, lower_limit_irq);
    endtask : t_limits
    task automatic t_bound();
        push(16'h7ff0, 4'h2);
        push(16'h0ff0, 4'h5);
        push(16'h8000, 4'h5);
        chk("upper below", 0, upper_limit_hit);
        chk("lower off chan", 0, lower_limit_hit);
    endtask : t_bound
    task automatic t_fill();
        pulse_clear();
        for (int i = 0; i < 32; i++) push(16'h0100 + 16'(i), 4'h0);
        chk("level full", 32, fifo_level);
        @(posedge ref_clk);
        sample_valid <= 1'b1;
        #1;
        chk("ready full", 0, sample_ready);
        @(posedge ref_clk);
        sample_valid <= 1'b0;
        host.wr(SFL_READ_ADDR, 24'h00abcd);
        host.rd(SFL_READ_ADDR, d);
        chk("read only port", 24'h000100, d);
        chk("level pop", 31, fifo_level);
        pulse_clear();
        chk("empty clear", 1, empty_flag);
        chk("level clear", 0, fifo_level);
    endtask : t_fill
    task automatic t_disable();
        push(16'h5555, 4'h0);
        chk("empty one", 0, empty_flag);
        @(posedge ref_clk);
        fifo_enable <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk("empty disabled", 1, empty_flag);
        chk("ready disabled", 0, sample_ready);
        @(posedge ref_clk);
        fifo_enable <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk("empty enabled", 1, empty_flag);
        chk("irq enabled", 1, empty_irq);
    endtask : t_disable
    task automatic results();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    initial begin
        mismatches = 0;
        samples_checked = 0;
        cyc = 0;
        reset = 1'b1;
        fifo_enable = 1'b1;
        fifo_clear = 1'b0;
        channel_limit_check_on = 16'h0000;
        sample_valid = 1'b0;
        sample_data = 16'h0000;
        sample_chan = 4'h0;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        #1;
        t_reset();
        t_limits();
        t_bound();
        t_fill();
        t_disable();
        results();
    end
endmodule : tb_top
